// ==== design/sbtc_pkg.sv ====
// Package for the sixteen-bit timer/counter: register map, fields, types
package sbtc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0]  IDX_FLAGS    = 8'h0c;
  localparam logic [7:0]  IDX_COUNT_LO = 8'h0e;
  localparam logic [7:0]  IDX_COUNT_HI = 8'h0f;
  localparam logic [7:0]  IDX_CONTROL  = 8'h10;
  localparam logic [7:0]  IDX_ENABLES  = 8'h8c;
  localparam int          ADDR_W       = 12;
  localparam int          IDX_LSB      = 2;

  // ==========================================================
  // Control field positions and reset values
  localparam int          CTL_RUN      = 0;
  localparam int          CTL_CLKSEL   = 1;
  localparam int          CTL_NOSYNC   = 2;
  localparam int          CTL_OSCEN    = 3;
  localparam int          CTL_PS_LO    = 4;
  localparam int          CTL_W        = 6;
  localparam logic [5:0]  CTL_RESET    = 6'h00;
  localparam int          OVF_BIT      = 0;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;

  // ==========================================================
  // Instruction cycle phases (oscillator divided by four) and prescaler select codes
  localparam logic [1:0]  PH_SECOND    = 2'h1;
  localparam logic [1:0]  PH_FOURTH    = 2'h3;
  localparam logic [1:0]  PH_LAST      = 2'h3;
  localparam logic [1:0]  PS_DIV1      = 2'h0;
  localparam logic [1:0]  PS_DIV2      = 2'h1;
  localparam logic [1:0]  PS_DIV4      = 2'h2;

  typedef enum logic [1:0] {
    SBTC_MODE_TIMER = 2'b00,
    SBTC_MODE_SYNC  = 2'b01,
    SBTC_MODE_ASYNC = 2'b10
  } sbtc_mode_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } sbtc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sbtc_apb_rsp_t;

  typedef struct packed {
    logic osc_enable;
    logic pin_zero_force_in;
    logic pin_one_force_in;
    logic overflow_irq;
    logic wake;
    logic timebase_valid;
  } sbtc_side_t;

endpackage : sbtc_pkg

// ==== design/sbtc_timer.sv ====
// Sixteen-bit timer/counter with prescaler, APB register slave and overflow flag
//
// Summary of operation
// - Count is 16 bits in two RW byte halves, 0000 to ffff, wraps.
// - Wrap from ffff to 0000 sets the latched overflow flag, flags bit 0.
// - Overflow request goes out only while enable bit 0 is set.
// - Select clear: count at oscillator/4; select set: external rising edges.
// - Count advances only while run bit 0 is set.
// - Reset input from either compare unit clears the count, except in unsynchronised counter mode.
// - Oscillator enable forces port pins to inputs; older parts only upper pin.
// - Prescale field 5:4: 11 div8, 10 div4, 01 div2, 00 none.
// - Oscillator enable bit switches the low-frequency oscillator on and off.
// - Sync control bit 2 is ignored when the internal clock is selected.
// - Counter mode clock: oscillator input pin if enabled, else external pin.
// - Sync mode synchronises after the prescaler; prescaler is free-running.
// - In sleep sync mode the count halts while the prescaler keeps counting.
// - Prescaler output is sampled on second and fourth phases.
// - Sync mode count advances a short delay after the external edge.
// - Unsynchronised counter runs in sleep and its overflow wakes the core.
// - Unsynchronised counter is not offered as compare/capture time base.
// - Control bits 7 and 6 read as zero.
// - Compare trigger resets count without flag; a coincident write wins.
// - Any write to either count byte clears the prescaler.
`timescale 1ns/1ps
`default_nettype none

module sbtc_timer
  import sbtc_pkg::*;
#(
  parameter bit FORCE_BOTH_PINS = 1'b1
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire sbtc_apb_req_t apb_req,
  output var  sbtc_apb_rsp_t apb_rsp,
  input  wire logic          ext_clock_pin,
  input  wire logic          osc_input_pin,
  input  wire logic          sleep,
  input  wire logic          compare_unit_one_trig,
  input  wire logic          compare_unit_two_trig,
  output var  sbtc_side_t    side,
  output logic [15:0]        sixteen_bit_count
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0]       count;
    logic [CTL_W-1:0]  ctrl;
    logic              ovf_flag;
    logic              ovf_ien;
    logic [2:0]        pscnt;
    logic              pin_prev;
    logic [1:0]        phase;
    logic              pending;
    sbtc_apb_rsp_t     rsp;
    sbtc_side_t        side;
  } sbtc_state_t;

  sbtc_state_t s_reg;
  sbtc_state_t s_next;

  // ==========================================================
  // Decode helpers
  logic              clksel;
  logic              nosync;
  logic              oscen;
  logic [1:0]        ps_sel;
  sbtc_mode_t        mode;
  logic              src_pin;
  logic              ps_in_ev;
  logic              ps_out_ev;
  logic              inc;
  logic              access;
  logic              wr_stb;
  logic [7:0]        idx;
  logic              hit;
  logic [31:0]       rd_val;
  logic [15:0]       cnt_inc;

  always_comb begin
    clksel  = s_reg.ctrl[CTL_CLKSEL];
    nosync  = s_reg.ctrl[CTL_NOSYNC];
    oscen   = s_reg.ctrl[CTL_OSCEN];
    ps_sel  = s_reg.ctrl[CTL_PS_LO +: 2];
    // Sync bit only matters for an external source
    if (!clksel) begin
      mode = SBTC_MODE_TIMER;
    end else if (nosync) begin
      mode = SBTC_MODE_ASYNC;
    end else begin
      mode = SBTC_MODE_SYNC;
    end
    src_pin = oscen ? osc_input_pin : ext_clock_pin;
    // Prescaler input: one tick per instruction cycle or per pin rising edge
    if (mode == SBTC_MODE_TIMER) begin
      // The instruction clock stops in sleep
      ps_in_ev = (s_reg.phase == PH_LAST) && !sleep;
    end else begin
      // Prescaler stays alive in sleep, like the ripple stage it models
      ps_in_ev = src_pin && !s_reg.pin_prev;
    end
    case (ps_sel)
      PS_DIV1: ps_out_ev = ps_in_ev;
      PS_DIV2: ps_out_ev = ps_in_ev && s_reg.pscnt[0];
      PS_DIV4: ps_out_ev = ps_in_ev && (&s_reg.pscnt[1:0]);
      default: ps_out_ev = ps_in_ev && (&s_reg.pscnt);
    endcase
    case (mode)
      SBTC_MODE_SYNC: begin
        // Synchroniser is off in sleep, so nothing reaches the count
        inc = s_reg.pending && !sleep &&
              (s_reg.phase == PH_SECOND || s_reg.phase == PH_FOURTH);
      end
      SBTC_MODE_ASYNC: inc = ps_out_ev;
      default:         inc = ps_out_ev;
    endcase
    inc = inc && s_reg.ctrl[CTL_RUN];
    cnt_inc = s_reg.count + 16'h0001;
    access = apb_req.psel && apb_req.penable;
    wr_stb = access && apb_req.pwrite && s_reg.rsp.pready;
    idx    = apb_req.paddr[IDX_LSB +: 8];
    hit    = (apb_req.paddr[ADDR_W-1:IDX_LSB+8] == '0) &&
             (apb_req.paddr[IDX_LSB-1:0] == '0) &&
             (idx == IDX_FLAGS || idx == IDX_COUNT_LO || idx == IDX_COUNT_HI ||
              idx == IDX_CONTROL || idx == IDX_ENABLES);
    rd_val = 32'h0000_0000;
    case (idx)
      IDX_FLAGS:    rd_val[OVF_BIT] = s_reg.ovf_flag;
      IDX_ENABLES:  rd_val[OVF_BIT] = s_reg.ovf_ien;
      IDX_COUNT_LO: rd_val[7:0] = s_reg.count[7:0];
      IDX_COUNT_HI: rd_val[7:0] = s_reg.count[15:8];
      IDX_CONTROL:  rd_val[CTL_W-1:0] = s_reg.ctrl;
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    s_next.phase    = s_reg.phase + 2'h1;
    s_next.pin_prev = src_pin;
    if (ps_in_ev) begin
      s_next.pscnt = s_reg.pscnt + 3'h1;
    end
    // Edge waits in the synchroniser for the next sampling phase
    if (mode != SBTC_MODE_SYNC || sleep || inc) begin
      s_next.pending = 1'b0;
    end
    if (mode == SBTC_MODE_SYNC && ps_out_ev) begin
      s_next.pending = 1'b1;
    end
    // Count: increment, then compare reset, then software write on top
    if (inc) begin
      s_next.count = cnt_inc;
    end
    // Trigger cannot act reliably on an unsynchronised counter
    if ((compare_unit_one_trig || compare_unit_two_trig) && mode != SBTC_MODE_ASYNC) begin
      s_next.count = COUNT_RESET;
    end
    // Bus answers with one wait state so read data comes from a flop
    s_next.rsp.pready  = access && !s_reg.rsp.pready;
    s_next.rsp.pslverr = access && !s_reg.rsp.pready && !hit;
    s_next.rsp.prdata  = (access && !s_reg.rsp.pready && !apb_req.pwrite && hit) ? rd_val
                                                                               : 32'h0000_0000;
    if (wr_stb && hit) begin
      case (idx)
        IDX_FLAGS:    s_next.ovf_flag = apb_req.pwdata[OVF_BIT];
        IDX_ENABLES:  s_next.ovf_ien  = apb_req.pwdata[OVF_BIT];
        IDX_CONTROL:  s_next.ctrl     = apb_req.pwdata[CTL_W-1:0];
        IDX_COUNT_LO: begin
          s_next.count[7:0] = apb_req.pwdata[7:0];
          s_next.pscnt      = 3'h0;
          s_next.pending    = 1'b0;
        end
        IDX_COUNT_HI: begin
          s_next.count[15:8] = apb_req.pwdata[7:0];
          s_next.pscnt       = 3'h0;
          s_next.pending     = 1'b0;
        end
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    // Hardware set beats a same-cycle software clear; trigger never sets it
    if (inc && s_reg.count == COUNT_MAX) begin
      s_next.ovf_flag = 1'b1;
    end
    // ========================================================
    // Side outputs, registered
    s_next.side.osc_enable        = s_next.ctrl[CTL_OSCEN];
    s_next.side.pin_one_force_in  = s_next.ctrl[CTL_OSCEN];
    s_next.side.pin_zero_force_in = s_next.ctrl[CTL_OSCEN] && FORCE_BOTH_PINS;
    s_next.side.overflow_irq      = s_next.ovf_flag && s_next.ovf_ien;
    s_next.side.wake              = s_next.ovf_flag && s_next.ovf_ien &&
                                    s_next.ctrl[CTL_CLKSEL] && s_next.ctrl[CTL_NOSYNC];
    s_next.side.timebase_valid    = !(s_next.ctrl[CTL_CLKSEL] && s_next.ctrl[CTL_NOSYNC]);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg                        <= '0;
      s_reg.count                  <= COUNT_RESET;
      s_reg.ctrl                   <= CTL_RESET;
      s_reg.side.timebase_valid    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp           = s_reg.rsp;
  assign side              = s_reg.side;
  assign sixteen_bit_count = s_reg.count;

endmodule : sbtc_timer

`default_nettype wire

// ==== sim/sbtc_properties.sv ====
// Port-level assertions for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module sbtc_properties
  import sbtc_pkg::*;
#(
  parameter bit FORCE_BOTH_PINS = 1'b1
) (
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire sbtc_apb_req_t apb_req,
  input wire sbtc_apb_rsp_t apb_rsp,
  input wire logic          compare_unit_one_trig,
  input wire logic          compare_unit_two_trig,
  input wire sbtc_side_t    side,
  input wire logic [15:0]   sixteen_bit_count
);
  logic wr;
  logic trg;
  assign wr  = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  assign trg = compare_unit_one_trig | compare_unit_two_trig;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // Properties
  sequence s_access; apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable; endsequence
  property p_ready; s_access |=> apb_rsp.pready ##1 !apb_rsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not a single pulse after one wait");
  property p_step; $changed(sixteen_bit_count) && !$past(rst) && !$past(wr) && !$past(trg)
    |-> sixteen_bit_count == $past(sixteen_bit_count) + 16'h1; endproperty
  a_step: assert property (p_step) else $error("count moved by other than one");
  property p_trig; trg && !wr && side.timebase_valid |=> sixteen_bit_count == 16'h0; endproperty
  a_trig: assert property (p_trig) else $error("trigger did not clear count");
  property p_wrwin; wr && apb_req.paddr == 12'h038
    |=> sixteen_bit_count[7:0] == $past(apb_req.pwdata[7:0]); endproperty
  a_wrwin: assert property (p_wrwin) else $error("low byte write lost");
  property p_pins; side.pin_one_force_in == side.osc_enable
    && side.pin_zero_force_in == (side.osc_enable & FORCE_BOTH_PINS); endproperty
  a_pins: assert property (p_pins) else $error("pin forcing wrong");
  property p_hold; side.overflow_irq && !wr && !$past(wr) |=> side.overflow_irq; endproperty
  a_hold: assert property (p_hold) else $error("overflow request dropped");
  property p_cause; $rose(side.overflow_irq) |-> $past(sixteen_bit_count) == 16'hffff
    || $past(sixteen_bit_count, 2) == 16'hffff || $past(wr) || $past(wr, 2); endproperty
  a_cause: assert property (p_cause) else $error("overflow request without wrap");
  property p_wake; side.wake |-> side.overflow_irq && !side.timebase_valid; endproperty
  a_wake: assert property (p_wake) else $error("wake outside unsynchronised mode");
  property p_ctl0; apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h040 |-> apb_rsp.prdata[31:6] == 26'h0;
  endproperty
  a_ctl0: assert property (p_ctl0) else $error("control top bits not zero");
endmodule : sbtc_properties
bind sbtc_timer sbtc_properties #(.FORCE_BOTH_PINS(FORCE_BOTH_PINS)) sbtc_properties_inst (.clk_sys, .rst, .apb_req,
  .apb_rsp, .compare_unit_one_trig, .compare_unit_two_trig, .side, .sixteen_bit_count);
`default_nettype wire

// ==== sim/sbtc_ext_src.sv ====
// Model of the external clock or crystal feeding the counter input
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_src (
  input  wire logic clk_sys,
  input  wire logic run,
  input  wire logic use_osc,
  output var  logic ext_clock_pin,
  output var  logic osc_input_pin
);
  logic ph_reg;
  logic lvl_reg;
  // ==========================================================
  // High two and low two periods, the tightest legal input
  always_ff @(posedge clk_sys) begin
    ph_reg  <= run & ~ph_reg;
    lvl_reg <= run & (lvl_reg ^ ph_reg);
  end
  // Stands low between bursts; the unused pin never moves
  assign ext_clock_pin = ~use_osc & lvl_reg;
  assign osc_input_pin = use_osc & lvl_reg;
endmodule : sbtc_ext_src
`default_nettype wire

// ==== sim/sbtc_timer_tb.sv ====
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer_tb;
  import sbtc_pkg::*;
  logic clk_sys, rst, sleep, trig1, trig2, src_run, use_osc, ext_pin, osc_pin, er;
  sbtc_apb_req_t req;
  sbtc_apb_rsp_t rsp;
  sbtc_side_t    side;
  logic [15:0]   cnt, cs;
  logic [31:0]   rd, sd;
  int            mismatches, total_checks;
  // ==========================================================
  // Clock, design and source model
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  sbtc_timer sbtc_timer_inst (.clk_sys, .rst, .apb_req(req), .apb_rsp(rsp), .ext_clock_pin(ext_pin),
    .osc_input_pin(osc_pin), .sleep, .compare_unit_one_trig(trig1), .compare_unit_two_trig(trig2), .side,
    .sixteen_bit_count(cnt));
  sbtc_ext_src sbtc_ext_src_inst (.clk_sys, .run(src_run), .use_osc, .ext_clock_pin(ext_pin), .osc_input_pin(osc_pin));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  // Waits for pready, holding the request; one idle edge on each side
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out();
    end else begin
      rd = rsp.prdata;
      er = rsp.pslverr;
      req <= '0;
      @(posedge clk_sys);
    end
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rchk
  // Count gain over a window whose length is a whole number of count periods
  task automatic meas(input logic [7:0] c, input logic o, input int win, input logic [15:0] e);
    logic [15:0] c0;
    apb(1'b1, 12'h040, {24'h0, c});
    use_osc <= o;
    src_run <= 1'b1;
    repeat (24) @(posedge clk_sys);
    c0 = cnt;
    repeat (win) @(posedge clk_sys);
    chk("count gain", {16'h0, e}, {16'h0, cnt - c0});
    src_run <= 1'b0;
  endtask : meas
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst, sleep, trig1, trig2, src_run, use_osc} = 6'h20;
    req = '0;
    sd = 32'h382e1068;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rchk("control", 12'h040, 32'h0);
    for (int i = 0; i < 4; i++) begin
      sd = xs(sd);
      apb(1'b1, 12'h040, sd & 32'hfffffffe);
      rchk("control", 12'h040, sd & 32'h3e);
      chk("pins", {29'h0, {3{sd[3]}}},
          {29'h0, side.osc_enable, side.pin_zero_force_in, side.pin_one_force_in});
      apb(1'b1, 12'h038, sd & 32'hff);
      apb(1'b1, 12'h03c, (sd >> 8) & 32'hff);
      chk("count", {16'h0, sd[15:0]}, {16'h0, cnt});
    end
    apb(1'b0, 12'h044, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    for (int p = 0; p < 4; p++) meas(8'h01 | 8'(p << 4), 1'b0, 32 << p, 16'h8);
    meas(8'h00, 1'b0, 40, 16'h0);
    meas(8'h05, 1'b0, 32, 16'h8);
    meas(8'h03, 1'b0, 32, 16'h8);
    meas(8'h0b, 1'b1, 32, 16'h8);
    meas(8'h03, 1'b1, 32, 16'h0);
    meas(8'h13, 1'b0, 64, 16'h8);
    sleep <= 1'b1;
    meas(8'h03, 1'b0, 32, 16'h0);
    meas(8'h07, 1'b0, 32, 16'h8);
    chk("timebase", 32'h0, {31'h0, side.timebase_valid});
    // Three edges left in the divide-by-eight prescaler; the count write must drop them
    apb(1'b1, 12'h040, 32'h37);
    apb(1'b1, 12'h038, 32'h0);
    src_run <= 1'b1;
    repeat (12) @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    apb(1'b1, 12'h03c, 32'h0);
    cs = cnt;
    src_run <= 1'b1;
    repeat (20) @(posedge clk_sys);
    src_run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("prescaler clear", 32'h0, {16'h0, cnt - cs});
    sleep <= 1'b0;
    // Stop the count before loading it, so no increment lands between the byte writes
    apb(1'b1, 12'h040, 32'h0);
    apb(1'b1, 12'h038, 32'hfd);
    apb(1'b1, 12'h03c, 32'hff);
    apb(1'b1, 12'h230, 32'h1);
    apb(1'b1, 12'h040, 32'h1);
    repeat (24) @(posedge clk_sys);
    rchk("flag", 12'h030, 32'h1);
    chk("irq", 32'h1, {31'h0, side.overflow_irq});
    chk("wake", 32'h0, {31'h0, side.wake});
    apb(1'b1, 12'h040, 32'h6);
    chk("wake", 32'h1, {31'h0, side.wake});
    apb(1'b1, 12'h040, 32'h1);
    chk("timebase", 32'h1, {31'h0, side.timebase_valid});
    apb(1'b1, 12'h230, 32'h0);
    chk("irq", 32'h0, {31'h0, side.overflow_irq});
    apb(1'b1, 12'h030, 32'h0);
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_sys);
      {trig2, trig1} <= 2'(1 << t);
      @(posedge clk_sys);
      {trig2, trig1} <= 2'b00;
      // The cleared count shows only after the edge that took the trigger
      @(posedge clk_sys);
      chk("trig count", 32'h0, {16'h0, cnt});
    end
    rchk("flag", 12'h030, 32'h0);
    close_out();
  end
endmodule : sbtc_timer_tb
`default_nettype wire
